// File: pfc_consts.svh
// pfc_consts.svh: offsets, field positions, reset values and timing counts
// for the per-port priority flow control block.
// assumes inclusion by bare name from the package and the design modules.
`ifndef PFC_CONSTS_SVH
`define PFC_CONSTS_SVH

// register word offsets (byte addresses, one aligned word each)
`define REG_CTRL 8'h00
`define REG_PRIO_ENA 8'h04
`define REG_TX_QUANTA 8'h08
`define REG_MIN_REFRESH 8'h0C
`define REG_STATUS 8'h10
`define REG_TX_COUNT 8'h14
`define REG_RX_COUNT 8'h18
`define REG_WMARK_BASE 8'h20
`define REG_WMARK_LAST 8'h3C

// control register fields
`define CTRL_TX_ENA_BIT 0
`define CTRL_RX_ENA_BIT 1
`define CTRL_SPEED_LO 2
`define CTRL_SPEED_HI 3

// reset values
`define CTRL_RESET 32'h0000_0008
`define PRIO_ENA_RESET 8'hFF
`define TX_QUANTA_RESET 16'hFFFF
`define MIN_REFRESH_RESET 16'h0100
`define WMARK_RESET 16'h0200

// frame constants
`define PFC_OPCODE 16'h0101
`define PFC_ENABLE_VECTOR 16'h00FF

// timing: one pause quantum is 512 bit times
`define CLK_PERIOD_NS 8
`define QUANTUM_BITS 512
`define BIT_NS_10M 100
`define BIT_NS_100M 10
`define BIT_NS_1G 1
`define QUANTUM_CYC_10M ((`QUANTUM_BITS * `BIT_NS_10M) / `CLK_PERIOD_NS)
`define QUANTUM_CYC_100M ((`QUANTUM_BITS * `BIT_NS_100M) / `CLK_PERIOD_NS)
`define QUANTUM_CYC_1G ((`QUANTUM_BITS * `BIT_NS_1G) / `CLK_PERIOD_NS)

`endif

// File: pfc_pkg.sv
// pfc_pkg.sv: types shared by the priority flow control block.
// assumes pfc_consts.svh is on the include path.
`include "pfc_consts.svh"

package pfc_pkg;

  typedef enum logic [1:0] {
    SPEED_10M,
    SPEED_100M,
    SPEED_1G,
    SPEED_RSVD
  } link_speed_e;

  typedef enum logic [1:0] {
    TX_IDLE,
    TX_WAIT,
    TX_SEND
  } tx_state_e;

  // pause pdu as seen by the mac on either direction
  typedef struct packed {
    logic [15:0] opcode;
    logic [15:0] enable_vector;
    logic [7:0][15:0] pause_time;
  } pfc_pdu_s;

  // register access from software
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wr_data;
    logic wr;
    logic rd;
  } reg_req_s;

endpackage : pfc_pkg

// File: quanta_ticker.sv
// quanta_ticker.sv: one-cycle pulse at the end of every pause quantum.
// assumes a free-running clock; the period follows the selected link speed.
`timescale 1ns/100ps
`default_nettype none
`include "pfc_consts.svh"

module quanta_ticker
  import pfc_pkg::*;
#(
  parameter int CYC_10M = `QUANTUM_CYC_10M,
  parameter int CYC_100M = `QUANTUM_CYC_100M,
  parameter int CYC_1G = `QUANTUM_CYC_1G
)
(
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire link_speed_e speed_in,
  output logic tick_out
);

  // counts must fit the 16-bit divider and be at least one cycle
  if (CYC_10M < 1 || CYC_10M > 65535 || CYC_100M < 1 || CYC_100M > 65535 || CYC_1G < 1 || CYC_1G > 65535)
  begin : g_bad_counts
    $error("quanta_ticker: quantum counts out of range");
  end

  logic [15:0] div_cnt;
  logic [15:0] div_last;

  // last count for the current speed; reserved code behaves as 1G
  always_comb
  begin
    case (speed_in)
      SPEED_10M: div_last = 16'(CYC_10M - 1);
      SPEED_100M: div_last = 16'(CYC_100M - 1);
      default: div_last = 16'(CYC_1G - 1);
    endcase
  end

  // divider, restarts when it reaches or passes the end after a speed change
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      div_cnt <= 16'h0000;
      tick_out <= 1'b0;
    end
    else if (div_cnt >= div_last)
    begin
      div_cnt <= 16'h0000;
      tick_out <= 1'b1;
    end
    else
    begin
      div_cnt <= div_cnt + 16'h0001;
      tick_out <= 1'b0;
    end
  end

endmodule : quanta_ticker
`default_nettype wire

// File: priority_flow_control.sv
// priority_flow_control.sv: per-port priority flow control, transmit pause
// generation and receive pause reaction, with its register file.
// assumes a mac that takes pause pdus on a valid/ready pair and hands parsed
// control frames over as one-cycle pulses; all inputs synchronous to ref_clk_in.
`timescale 1ns/100ps
`default_nettype none
`include "pfc_consts.svh"

module priority_flow_control
  import pfc_pkg::*;
#(
  parameter int LEVEL_W = 16,
  parameter int CYC_10M = `QUANTUM_CYC_10M,
  parameter int CYC_100M = `QUANTUM_CYC_100M,
  parameter int CYC_1G = `QUANTUM_CYC_1G
)
(
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire reg_req_s reg_req_in,
  output logic [31:0] rd_data_out,
  input wire logic [7:0][LEVEL_W-1:0] queue_level_in,
  output pfc_pdu_s tx_pdu_out,
  output logic tx_pdu_valid_out,
  input wire logic tx_pdu_ready_in,
  input wire pfc_pdu_s rx_ctrl_in,
  input wire logic rx_ctrl_valid_in,
  output logic [7:0] egress_stop_out
);

  // watermarks are 16-bit register fields
  if (LEVEL_W < 1 || LEVEL_W > 16)
  begin : g_bad_level_w
    $error("priority_flow_control: LEVEL_W must be 1..16");
  end

  // configuration and statistics state
  logic [31:0] ctrl;
  logic [7:0] prio_ena;
  logic [15:0] tx_pause_quanta;
  logic [15:0] min_refresh_interval;
  logic [7:0][15:0] watermark;
  logic [31:0] pause_tx_count;
  logic [31:0] unknown_opcode_rx_count;

  // transmit side state
  logic [7:0] congestion_vector;
  logic [7:0] congested_now;
  logic [7:0] newly_congested;
  tx_state_e tx_state;
  logic [15:0] elapsed;
  logic [15:0] advertised;
  logic refresh_pending;
  logic tx_done;
  logic half_passed;
  logic refresh_passed;
  logic send_now;

  // receive side state
  logic [7:0][15:0] rx_pause_cnt;
  logic rx_is_pfc;
  logic quantum_tick;

  logic tx_ena;
  logic rx_ena;
  link_speed_e speed;

  assign tx_ena = ctrl[`CTRL_TX_ENA_BIT];
  assign rx_ena = ctrl[`CTRL_RX_ENA_BIT];
  assign speed = link_speed_e'(ctrl[`CTRL_SPEED_HI:`CTRL_SPEED_LO]);

  // one quantum timebase shared by the tx timer and the rx counters
  quanta_ticker #(
    .CYC_10M(CYC_10M),
    .CYC_100M(CYC_100M),
    .CYC_1G(CYC_1G)
  ) u_ticker (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .speed_in(speed),
    .tick_out(quantum_tick)
  );

  // register writes; watermarks sit in a block of eight words
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      ctrl <= `CTRL_RESET;
      prio_ena <= `PRIO_ENA_RESET;
      tx_pause_quanta <= `TX_QUANTA_RESET;
      min_refresh_interval <= `MIN_REFRESH_RESET;
      watermark <= {8{`WMARK_RESET}};
    end
    else if (reg_req_in.wr)
    begin
      case (reg_req_in.addr)
        `REG_CTRL: ctrl <= {28'h0000000, reg_req_in.wr_data[3:0]};
        `REG_PRIO_ENA: prio_ena <= reg_req_in.wr_data[7:0];
        `REG_TX_QUANTA: tx_pause_quanta <= reg_req_in.wr_data[15:0];
        `REG_MIN_REFRESH: min_refresh_interval <= reg_req_in.wr_data[15:0];
        default:
        begin
          if (reg_req_in.addr >= `REG_WMARK_BASE && reg_req_in.addr <= `REG_WMARK_LAST
              && reg_req_in.addr[1:0] == 2'b00)
            watermark[reg_req_in.addr[4:2]] <= reg_req_in.wr_data[15:0];
        end
      endcase
    end
  end

  // register reads, data one cycle after the strobe, unmapped reads zero
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      rd_data_out <= 32'h0000_0000;
    else if (reg_req_in.rd)
    begin
      case (reg_req_in.addr)
        `REG_CTRL: rd_data_out <= ctrl;
        `REG_PRIO_ENA: rd_data_out <= {24'h000000, prio_ena};
        `REG_TX_QUANTA: rd_data_out <= {16'h0000, tx_pause_quanta};
        `REG_MIN_REFRESH: rd_data_out <= {16'h0000, min_refresh_interval};
        `REG_STATUS: rd_data_out <= {8'h00, 6'h00, tx_state, egress_stop_out, congestion_vector};
        `REG_TX_COUNT: rd_data_out <= pause_tx_count;
        `REG_RX_COUNT: rd_data_out <= unknown_opcode_rx_count;
        default:
        begin
          if (reg_req_in.addr >= `REG_WMARK_BASE && reg_req_in.addr <= `REG_WMARK_LAST
              && reg_req_in.addr[1:0] == 2'b00)
            rd_data_out <= {16'h0000, watermark[reg_req_in.addr[4:2]]};
          else
            rd_data_out <= 32'h0000_0000;
        end
      endcase
    end
    else
      rd_data_out <= 32'h0000_0000;
  end

  // per-queue watermark compare, one comparator per priority
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_cong
      assign congested_now[gi] = 16'(queue_level_in[gi]) > watermark[gi];
    end
  endgenerate

  // held congestion vector; rising bits start or speed up a pdu
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      congestion_vector <= 8'h00;
    else
      congestion_vector <= congested_now;
  end

  assign newly_congested = congested_now & ~congestion_vector;
  assign tx_done = tx_pdu_valid_out && tx_pdu_ready_in;
  assign half_passed = elapsed >= {1'b0, advertised[15:1]};
  assign refresh_passed = elapsed >= min_refresh_interval;

  // decision to start a pdu in the current cycle
  always_comb
  begin
    send_now = 1'b0;
    case (tx_state)
      TX_IDLE: send_now = tx_ena && (|newly_congested);
      TX_WAIT:
      begin
        if (tx_ena && (|newly_congested || refresh_pending) && refresh_passed)
          send_now = 1'b1;
        else if (tx_ena && (|congested_now) && half_passed)
          send_now = 1'b1;
      end
      default: send_now = 1'b0;
    endcase
  end

  // pdu generation state and the single per-port timer
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      tx_state <= TX_IDLE;
      elapsed <= 16'h0000;
      advertised <= 16'h0000;
    end
    else
    begin
      case (tx_state)
        TX_IDLE:
        begin
          elapsed <= 16'h0000;
          if (send_now)
            tx_state <= TX_SEND;
        end
        TX_WAIT:
        begin
          if (quantum_tick && elapsed != 16'hFFFF)
            elapsed <= elapsed + 16'h0001;
          if (send_now)
            tx_state <= TX_SEND;
          else if (!(|congested_now) && elapsed >= advertised)
            tx_state <= TX_IDLE;
        end
        TX_SEND:
        begin
          if (tx_done)
          begin
            tx_state <= TX_WAIT;
            elapsed <= 16'h0000;
            advertised <= tx_pause_quanta;
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // new congestion during a running timer is remembered; a new event beats the clear
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      refresh_pending <= 1'b0;
    else if (tx_state != TX_IDLE && (|newly_congested))
      refresh_pending <= 1'b1;
    else if (tx_done)
      refresh_pending <= 1'b0;
  end

  // pdu contents latched as the send starts and held until taken
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      tx_pdu_valid_out <= 1'b0;
      tx_pdu_out <= '0;
    end
    else if (send_now)
    begin
      tx_pdu_valid_out <= 1'b1;
      tx_pdu_out.opcode <= `PFC_OPCODE;
      tx_pdu_out.enable_vector <= `PFC_ENABLE_VECTOR;
      for (int i = 0; i < 8; i++)
        tx_pdu_out.pause_time[i] <= (prio_ena[i] && congested_now[i]) ? tx_pause_quanta : 16'h0000;
    end
    else if (tx_done)
      tx_pdu_valid_out <= 1'b0;
  end

  // shared transmitted pause counter
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      pause_tx_count <= 32'h0000_0000;
    else if (tx_done)
      pause_tx_count <= pause_tx_count + 32'h0000_0001;
  end

  // a received control frame with the pfc opcode
  assign rx_is_pfc = rx_ctrl_valid_in && rx_ctrl_in.opcode == `PFC_OPCODE;

  // pfc frames are counted as unsupported-opcode control frames
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      unknown_opcode_rx_count <= 32'h0000_0000;
    else if (rx_is_pfc)
      unknown_opcode_rx_count <= unknown_opcode_rx_count + 32'h0000_0001;
  end

  // per-priority receive pause counters; a fresh load beats the decrement
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_rx
      always_ff @(posedge ref_clk_in)
      begin
        if (sys_rst_in)
          rx_pause_cnt[gi] <= 16'h0000;
        else if (rx_ena && rx_is_pfc && rx_ctrl_in.enable_vector[gi])
          rx_pause_cnt[gi] <= rx_ctrl_in.pause_time[gi];
        else if (quantum_tick && rx_pause_cnt[gi] != 16'h0000)
          rx_pause_cnt[gi] <= rx_pause_cnt[gi] - 16'h0001;
      end

      // stop indication toward the egress queues
      always_ff @(posedge ref_clk_in)
      begin
        if (sys_rst_in)
          egress_stop_out[gi] <= 1'b0;
        else if (rx_ena && rx_is_pfc && rx_ctrl_in.enable_vector[gi])
          egress_stop_out[gi] <= rx_ctrl_in.pause_time[gi] != 16'h0000;
        else if (quantum_tick && rx_pause_cnt[gi] == 16'h0001)
          egress_stop_out[gi] <= 1'b0;
        else
          egress_stop_out[gi] <= rx_pause_cnt[gi] != 16'h0000;
      end
    end
  endgenerate

endmodule : priority_flow_control
`default_nettype wire

// File: pfc_props.sv
// pfc_props.sv: port assertions for priority_flow_control.
// assumes it is bound onto the top module; one clock domain.
`timescale 1ns/100ps
`default_nettype none
module pfc_props
  import pfc_pkg::*;
#(
  parameter int LEVEL_W = 16
)
(
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire reg_req_s reg_req_in,
  input wire logic [31:0] rd_data_out,
  input wire logic [7:0][LEVEL_W-1:0] queue_level_in,
  input wire pfc_pdu_s tx_pdu_out,
  input wire logic tx_pdu_valid_out,
  input wire logic tx_pdu_ready_in,
  input wire pfc_pdu_s rx_ctrl_in,
  input wire logic rx_ctrl_valid_in,
  input wire logic [7:0] egress_stop_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (sys_rst_in);
  logic [15:0] any_time;
  logic odd_time;
  // flags a pdu whose non-zero pause times are not all the same quanta
  always_comb
  begin
    any_time = 16'h0000;
    odd_time = 1'b0;
    for (int i = 0; i < 8; i++)
      any_time = any_time | tx_pdu_out.pause_time[i];
    for (int i = 0; i < 8; i++)
      if (tx_pdu_out.pause_time[i] != 16'h0000 && tx_pdu_out.pause_time[i] != any_time)
        odd_time = 1'b1;
  end
  sequence s_wait;
    tx_pdu_valid_out && !tx_pdu_ready_in;
  endsequence
  sequence s_accept;
    tx_pdu_valid_out && tx_pdu_ready_in;
  endsequence
  property p_pdu_hold;
    s_wait |=> tx_pdu_valid_out && $stable(tx_pdu_out);
  endproperty
  property p_valid_drop;
    s_accept |=> !tx_pdu_valid_out;
  endproperty
  property p_enable_vec;
    tx_pdu_valid_out |-> tx_pdu_out.enable_vector == 16'h00FF;
  endproperty
  property p_opcode;
    tx_pdu_valid_out |-> tx_pdu_out.opcode == 16'h0101;
  endproperty
  property p_same_quanta;
    tx_pdu_valid_out |-> !odd_time;
  endproperty
  property p_stop_cause;
    (egress_stop_out & ~$past(egress_stop_out)) != 8'h00
      |-> $past(rx_ctrl_valid_in) && $past(rx_ctrl_in.opcode) == 16'h0101;
  endproperty
  property p_stop_enabled;
    ((egress_stop_out & ~$past(egress_stop_out)) & ~$past(rx_ctrl_in.enable_vector[7:0])) == 8'h00;
  endproperty
  property p_rd_idle;
    !reg_req_in.rd |=> rd_data_out == 32'h0000_0000;
  endproperty
  property p_status_stop;
    reg_req_in.rd && reg_req_in.addr == 8'h10 |=> rd_data_out[15:8] == $past(egress_stop_out);
  endproperty
  a_pdu_hold: assert property (p_pdu_hold) else $error("pdu changed while waiting");
  a_valid_drop: assert property (p_valid_drop) else $error("valid held after accept");
  a_enable_vec: assert property (p_enable_vec) else $error("bad enable vector");
  a_opcode: assert property (p_opcode) else $error("bad opcode");
  a_same_quanta: assert property (p_same_quanta) else $error("mixed pause times");
  a_stop_cause: assert property (p_stop_cause) else $error("stop without frame");
  a_stop_enabled: assert property (p_stop_enabled) else $error("stop on disabled bit");
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  a_status_stop: assert property (p_status_stop) else $error("status stop mismatch");
endmodule : pfc_props
bind priority_flow_control pfc_props #(.LEVEL_W(LEVEL_W)) props_u (
  .ref_clk_in(ref_clk_in),
  .sys_rst_in(sys_rst_in),
  .reg_req_in(reg_req_in),
  .rd_data_out(rd_data_out),
  .queue_level_in(queue_level_in),
  .tx_pdu_out(tx_pdu_out),
  .tx_pdu_valid_out(tx_pdu_valid_out),
  .tx_pdu_ready_in(tx_pdu_ready_in),
  .rx_ctrl_in(rx_ctrl_in),
  .rx_ctrl_valid_in(rx_ctrl_valid_in),
  .egress_stop_out(egress_stop_out)
);
`default_nettype wire

// File: pfc_link_partner.sv
// pfc_link_partner.sv: remote mac at the far end of the pause link.
// assumes the bench sets stall and calls send_frame.
`timescale 1ns/100ps
`default_nettype none
module pfc_link_partner
  import pfc_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire pfc_pdu_s tx_pdu_in,
  input wire logic tx_pdu_valid_in,
  output logic tx_pdu_ready_out,
  output pfc_pdu_s rx_ctrl_out,
  output logic rx_ctrl_valid_out
);
  int stall = 0;
  int waited = 0;
  int got = 0;
  pfc_pdu_s last_pdu = '0;
  initial
  begin
    tx_pdu_ready_out = 1'b0;
    rx_ctrl_out = '0;
    rx_ctrl_valid_out = 1'b0;
  end
  // accepts each pdu after stall cycles and keeps the last one
  always @(posedge ref_clk_in)
  begin
    if (tx_pdu_valid_in && tx_pdu_ready_out)
    begin
      tx_pdu_ready_out <= 1'b0;
      last_pdu <= tx_pdu_in;
      got <= got + 1;
      waited <= 0;
    end
    else if (tx_pdu_valid_in && !sys_rst_in && waited >= stall)
      tx_pdu_ready_out <= 1'b1;
    else if (tx_pdu_valid_in && !sys_rst_in)
    begin
      tx_pdu_ready_out <= 1'b0;
      waited <= waited + 1;
    end
    else
      tx_pdu_ready_out <= 1'b0;
  end
  // one received control frame; the lines are inverted once released
  task automatic send_frame(input pfc_pdu_s f);
    @(posedge ref_clk_in);
    rx_ctrl_out <= f;
    rx_ctrl_valid_out <= 1'b1;
    @(posedge ref_clk_in);
    rx_ctrl_valid_out <= 1'b0;
    rx_ctrl_out <= ~f;
  endtask : send_frame
endmodule : pfc_link_partner
`default_nettype wire

// File: priority_flow_control_test.sv
// priority_flow_control_test.sv: self-checking bench for priority_flow_control.
// assumes pfc_props is bound and pfc_link_partner stands on the pdu side.
`timescale 1ns/100ps
`default_nettype none
`include "pfc_consts.svh"
module priority_flow_control_test;
  import pfc_pkg::*;
  logic ref_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  reg_req_s reg_req = '0;
  logic [7:0][15:0] level = '0;
  logic [31:0] rd_data;
  pfc_pdu_s tx_pdu;
  pfc_pdu_s rx_ctrl;
  logic tx_valid;
  logic tx_ready;
  logic rx_valid;
  logic [7:0] stop;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  // short quanta keep the run brief
  priority_flow_control #(.LEVEL_W(16), .CYC_10M(16), .CYC_100M(8), .CYC_1G(4)) dut_u (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .reg_req_in(reg_req), .rd_data_out(rd_data),
    .queue_level_in(level), .tx_pdu_out(tx_pdu), .tx_pdu_valid_out(tx_valid), .tx_pdu_ready_in(tx_ready),
    .rx_ctrl_in(rx_ctrl), .rx_ctrl_valid_in(rx_valid), .egress_stop_out(stop));
  pfc_link_partner mac_u (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .tx_pdu_in(tx_pdu), .tx_pdu_valid_in(tx_valid),
    .tx_pdu_ready_out(tx_ready), .rx_ctrl_out(rx_ctrl), .rx_ctrl_valid_out(rx_valid));
  // 125 MHz clock
  always #4 ref_clk_in = ~ref_clk_in;
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish
  // hang guard
  always @(posedge ref_clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    reg_req <= '{addr: a, wr_data: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_in);
    reg_req.wr <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge ref_clk_in);
    reg_req <= '{addr: a, wr_data: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk_in);
    reg_req.rd <= 1'b0;
    #1 chk(rd_data, exp, what);
  endtask : rd_chk
  task automatic wait_pdu(input int lo, input int hi);
    int n = 0;
    int start = mac_u.got;
    while (mac_u.got == start && n <= hi)
    begin
      @(posedge ref_clk_in);
      #1 n++;
    end
    chk(32'(n >= lo && n <= hi), 32'h1, "pdu timing");
  endtask : wait_pdu
  task automatic no_pdu(input int n);
    int start = mac_u.got;
    repeat (n) @(posedge ref_clk_in);
    #1 chk(mac_u.got, start, "unexpected pdu");
  endtask : no_pdu
  task automatic pdu_chk(input logic [15:0] t2, input logic [15:0] t3);
    pfc_pdu_s p = mac_u.last_pdu;
    chk({p.opcode, p.enable_vector}, 32'h0101_00FF, "pdu header");
    for (int i = 0; i < 8; i++)
      chk({16'h0, p.pause_time[i]}, {16'h0, i == 2 ? t2 : i == 3 ? t3 : 16'h0}, "pause time");
  endtask : pdu_chk
  task automatic test_reset();
    logic [7:0] a [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h20, 8'h3C, 8'h40};
    logic [31:0] v [10] = '{32'h8, 32'hFF, 32'hFFFF, 32'h100, 32'h0, 32'h0, 32'h0, 32'h200, 32'h200, 32'h0};
    for (int i = 0; i < 10; i++)
      rd_chk(a[i], v[i], "reset value");
  endtask : test_reset
  task automatic test_tx();
    wr(`REG_TX_QUANTA, 32'h10);
    wr(`REG_MIN_REFRESH, 32'h1);
    wr(`REG_PRIO_ENA, 32'hF7);
    wr(`REG_CTRL, 32'h9);
    mac_u.stall = 3;
    level[2] <= 16'h0201;
    wait_pdu(2, 10);
    pdu_chk(16'h10, 16'h0);
    @(posedge ref_clk_in);
    level[3] <= 16'h0201;
    wait_pdu(2, 16);
    pdu_chk(16'h10, 16'h0);
    wait_pdu(26, 45);
    pdu_chk(16'h10, 16'h0);
    wr(`REG_TX_COUNT, 32'h0);
    rd_chk(`REG_TX_COUNT, 32'h3, "sent count");
    @(posedge ref_clk_in);
    level[2] <= 16'h0200;
    level[3] <= 16'h0200;
    no_pdu(120);
    wr(`REG_CTRL, 32'h8);
    level[1] <= 16'h0201;
    no_pdu(30);
    rd_chk(`REG_STATUS, 32'h2, "status");
    @(posedge ref_clk_in);
    level[1] <= 16'h0200;
  endtask : test_tx
  task automatic test_rx();
    pfc_pdu_s f = '0;
    int n;
    int cyc;
    f.opcode = 16'h0101;
    f.enable_vector = 16'h0004;
    f.pause_time[2] = 16'h2;
    f.pause_time[5] = 16'h7;
    for (int s = 0; s < 4; s++)
    begin
      wr(`REG_CTRL, 32'(2 + 4 * s));
      mac_u.send_frame(f);
      #1 chk({24'h0, stop}, 32'h4, "stop set");
      n = 0;
      cyc = s == 0 ? 16 : s == 1 ? 8 : 4;
      while (stop !== 8'h00 && n < 40)
      begin
        @(posedge ref_clk_in);
        #1 n++;
      end
      chk(32'(n >= cyc && n <= 2 * cyc + 2), 32'h1, "stop length");
    end
    f.opcode = 16'h0001;
    mac_u.send_frame(f);
    #1 chk({24'h0, stop}, 32'h0, "other opcode");
    wr(`REG_CTRL, 32'h8);
    f.opcode = 16'h0101;
    mac_u.send_frame(f);
    #1 chk({24'h0, stop}, 32'h0, "reaction off");
    rd_chk(`REG_RX_COUNT, 32'h5, "received count");
  endtask : test_rx
  // reset, then the scenarios in turn
  initial
  begin
    repeat (16) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    test_reset();
    test_tx();
    test_rx();
    tally_and_finish();
  end
endmodule : priority_flow_control_test
`default_nettype wire
